/* hw/agw_cfg.svh */
// Constants for the ASCII command gateway port
`ifndef AGW_CFG_SVH
`define AGW_CFG_SVH
// =============================================
// Character codes
`define AGW_CH_CR 8'h0D
`define AGW_CH_SP 8'h20
`define AGW_CH_0 8'h30
`define AGW_CH_9 8'h39
`define AGW_CASE_MASK 8'hDF
`define AGW_LT_A 8'h41
`define AGW_LT_B 8'h42
`define AGW_LT_C 8'h43
`define AGW_LT_O 8'h4F
`define AGW_LT_P 8'h50
`define AGW_LT_R 8'h52
`define AGW_LT_S 8'h53
`define AGW_LT_W 8'h57
// =============================================
// Command termination
`define AGW_PKT_LAST 8'h7F
`define AGW_TMO_CS 100
`define AGW_CS_PER_S 100
`define AGW_CLK_HZ 40000000
`define AGW_TMO_CYC (`AGW_CLK_HZ / `AGW_CS_PER_S * `AGW_TMO_CS)
// =============================================
// Route, numbers, buffer
`define AGW_ROUTE_MAX 4'h8
`define AGW_PIDX_MAX 4'hF
`define AGW_BIT_MAX 16'h0010
`define AGW_LAST_DIG 3'h4
`define AGW_BUF_DEPTH 2
`define AGW_BUF_FULL 2'h2
`endif

/* hw/agw_dec_fmt.sv */
// Decimal reply formatter: a 16-bit value in ASCII digits, then one suffix
`timescale 1ns/10ps
`include "agw_cfg.svh"
module agw_dec_fmt (
   input wire logic i_clk,
   input wire logic i_rst_n,
   agw_fmt_if.fmt f,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ready
);
   typedef enum {F_IDLE, F_DIG, F_OUT, F_SUF} agw_fst_e;
   agw_fst_e fst_reg;
   logic [15:0] val_reg;
   logic [2:0] pos_reg;
   logic [3:0] dig_reg;
   logic lead_reg;
   logic [7:0] suf_reg;
   logic [7:0] tx_reg;
   logic [15:0] pw;

   // Digit found by repeated subtraction: slow but tiny, fine at serial rates
   always_comb
   begin
      case (pos_reg)
         3'h0: pw = 16'h2710;
         3'h1: pw = 16'h03E8;
         3'h2: pw = 16'h0064;
         3'h3: pw = 16'h000A;
         default: pw = 16'h0001;
      endcase
   end

   assign f.busy = (fst_reg != F_IDLE);
   assign o_tx_valid = (fst_reg == F_OUT) || (fst_reg == F_SUF);
   assign o_tx_data = tx_reg;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         fst_reg <= F_IDLE;
         val_reg <= 16'h0000;
         pos_reg <= 3'h0;
         dig_reg <= 4'h0;
         lead_reg <= 1'b0;
         suf_reg <= 8'h00;
         tx_reg <= 8'h00;
      end
      else
      begin
         case (fst_reg)
            F_IDLE:
               if (f.start)
               begin
                  val_reg <= f.value;
                  suf_reg <= f.suffix;
                  tx_reg <= f.suffix;
                  pos_reg <= 3'h0;
                  dig_reg <= 4'h0;
                  lead_reg <= 1'b0;
                  fst_reg <= f.dec ? F_DIG : F_SUF;
               end
            F_DIG:
               if (val_reg >= pw)
               begin
                  val_reg <= val_reg - pw;
                  dig_reg <= dig_reg + 4'h1;
               end
               else if ((dig_reg != 4'h0) || lead_reg || (pos_reg == `AGW_LAST_DIG))
               begin
                  // Leading zeros suppressed, a lone zero still printed
                  tx_reg <= `AGW_CH_0 | {4'h0, dig_reg};
                  fst_reg <= F_OUT;
               end
               else
                  pos_reg <= pos_reg + 3'h1;
            F_OUT:
               if (i_tx_ready)
               begin
                  lead_reg <= 1'b1;
                  dig_reg <= 4'h0;
                  if (pos_reg == `AGW_LAST_DIG)
                  begin
                     tx_reg <= suf_reg;
                     fst_reg <= F_SUF;
                  end
                  else
                  begin
                     pos_reg <= pos_reg + 3'h1;
                     fst_reg <= F_DIG;
                  end
               end
            F_SUF:
               if (i_tx_ready)
                  fst_reg <= F_IDLE;
            default:
               fst_reg <= F_IDLE;
         endcase
      end
   end
endmodule

/* hw/agw_fifo2.sv */
// Two-entry message buffer with valid/ready on both sides
`timescale 1ns/10ps
`include "agw_cfg.svh"
module agw_fifo2 (
   input wire logic i_clk,
   input wire logic i_rst_n,
   agw_word_if.snk i_in,
   agw_word_if.src o_out
);
   agw_pkg::agw_word_s mem_reg [`AGW_BUF_DEPTH];
   logic wp_reg;
   logic rp_reg;
   logic [1:0] cnt_reg;
   logic push;
   logic pop;

   assign i_in.ready = (cnt_reg != `AGW_BUF_FULL);
   assign o_out.valid = (cnt_reg != 2'h0);
   assign o_out.word = mem_reg[rp_reg];
   assign push = i_in.valid && i_in.ready;
   assign pop = o_out.valid && o_out.ready;

   for (genvar i = 0; i < `AGW_BUF_DEPTH; i++)
   begin : g_ent
      always_ff @(posedge i_clk)
      begin
         if (!i_rst_n)
            mem_reg[i] <= '0;
         else if (push && (wp_reg == 1'(i)))
            mem_reg[i] <= i_in.word;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         wp_reg <= 1'b0;
         rp_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end
      else
      begin
         if (push)
            wp_reg <= ~wp_reg;
         if (pop)
            rp_reg <= ~rp_reg;
         cnt_reg <= 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
      end
   end
endmodule

/* hw/agw_gateway.sv */
// ASCII command gateway port: parses letter commands, issues network messages
`timescale 1ns/10ps
`include "agw_cfg.svh"
// Notes on behaviour
// - One letter, decimal parameters, any delimiters; ends on CR or idle time.
// - Read: R, optional non-digits, register number ended by a non-digit.
// - Optional read count follows delimiters, ends at non-digit or packet end.
// - Read reply: decimal values, spaces between, carriage return after last.
// - Write: register then values; each further value goes to next register.
// - S with register and bit sends a write that forces that bit to one.
// - C with register and bit sends a write that forces that bit to zero.
// - B reads the register, then outputs ASCII 1 or 0 for the bit.
// - P forwards following text as print; far end appends CR and LF.
// - O forwards following text as print with no CR or LF added.
// - A with up to eight drops replaces the stored target route.
// - Empty route sends reads and writes to local registers, not network.
// - Route is held in configuration storage, set by config or address command.
module agw_gateway #(
   parameter int unsigned TMO_CYC = `AGW_TMO_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   output logic o_rx_ready,
   output logic o_msg_valid,
   input wire logic i_msg_ready,
   output logic [2:0] o_msg_kind,
   output logic o_msg_local,
   output logic [15:0] o_msg_addr,
   output logic [15:0] o_msg_data,
   input wire logic i_rsp_valid,
   input wire logic [15:0] i_rsp_data,
   output logic o_rsp_ready,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   input wire logic i_cfg_we,
   input wire logic [3:0] i_cfg_len,
   input wire logic [63:0] i_cfg_drops,
   output logic [3:0] o_route_len,
   output logic [63:0] o_route
);
   typedef enum {ST_IDLE, ST_PARSE, ST_EXEC, ST_RSP, ST_REPLY} agw_st_e;

   agw_word_if w_in();
   agw_word_if w_out();
   agw_fmt_if fmt();

   agw_st_e st_reg;
   agw_st_e st_next;
   agw_pkg::agw_cmd_e cmd_reg;
   logic innum_reg;
   logic [15:0] num_reg;
   logic [3:0] pidx_reg;
   logic [15:0] reg0_reg;
   logic [15:0] p1_reg;
   logic [15:0] waddr_reg;
   logic [7:0] nchar_reg;
   logic [31:0] tmo_reg;
   logic [7:0][7:0] route_reg;
   logic [3:0] rlen_reg;
   logic [7:0][7:0] nroute_reg;
   logic [3:0] nlen_reg;
   logic [15:0] rcnt_reg;

   logic rx_take;
   logic is_dig;
   logic is_cr;
   logic [7:0] dig_diff;
   logic [15:0] num_acc;
   logic [15:0] fin_num;
   logic prn;
   logic tmo_hit;
   logic end_evt;
   logic num_fire;
   logic bit_ok;
   logic [3:0] bitpos;
   logic [15:0] rd_cnt;
   logic exec_push;
   logic exec_go;
   logic rsp_take;

   // =============================================
   // Command letter decode
   function automatic agw_pkg::agw_cmd_e dec_cmd(input logic [7:0] ch);
      case (ch & `AGW_CASE_MASK)
         `AGW_LT_R: dec_cmd = agw_pkg::CMD_READ;
         `AGW_LT_W: dec_cmd = agw_pkg::CMD_WRITE;
         `AGW_LT_S: dec_cmd = agw_pkg::CMD_SET;
         `AGW_LT_C: dec_cmd = agw_pkg::CMD_CLR;
         `AGW_LT_B: dec_cmd = agw_pkg::CMD_BIT;
         `AGW_LT_P: dec_cmd = agw_pkg::CMD_PRINT;
         `AGW_LT_O: dec_cmd = agw_pkg::CMD_OMIT;
         `AGW_LT_A: dec_cmd = agw_pkg::CMD_ADDR;
         default: dec_cmd = agw_pkg::CMD_NONE;
      endcase
   endfunction

   // =============================================
   // Character classification and number accumulation
   assign rx_take = i_rx_valid && o_rx_ready;
   assign is_dig = (i_rx_data >= `AGW_CH_0) && (i_rx_data <= `AGW_CH_9);
   assign is_cr = (i_rx_data == `AGW_CH_CR);
   assign dig_diff = i_rx_data - `AGW_CH_0;
   assign num_acc = 16'(num_reg * 16'h000A + {12'h000, dig_diff[3:0]});
   assign fin_num = (rx_take && is_dig) ? num_acc : num_reg;
   assign prn = (cmd_reg == agw_pkg::CMD_PRINT) || (cmd_reg == agw_pkg::CMD_OMIT);

   // Timer only fires with buffer room, so a trailing value is never dropped
   assign tmo_hit = (st_reg == ST_PARSE) && (tmo_reg >= 32'(TMO_CYC - 1));
   assign end_evt = (st_reg == ST_PARSE) &&
      ((rx_take && (is_cr || (nchar_reg == `AGW_PKT_LAST))) ||
       (tmo_hit && w_in.ready));
   // A number closes on its first non-digit or at the end of the packet
   assign num_fire = (st_reg == ST_PARSE) && !prn &&
      ((rx_take && !is_dig && innum_reg) ||
       (end_evt && (innum_reg || (rx_take && is_dig))));

   assign bit_ok = (p1_reg != 16'h0000) && (p1_reg <= `AGW_BIT_MAX);
   assign bitpos = 4'(p1_reg[3:0] - 4'h1);
   assign rd_cnt = (p1_reg == 16'h0000) ? 16'h0001 : p1_reg;

   // Receiver is held off while the buffer is full, so no character is lost
   assign o_rx_ready = (st_reg == ST_IDLE) || ((st_reg == ST_PARSE) && w_in.ready);

   // =============================================
   // Outgoing message words
   always_comb
   begin
      exec_push = 1'b0;
      w_in.valid = 1'b0;
      w_in.word = '0;
      w_in.word.local_tgt = (rlen_reg == 4'h0);
      if (st_reg == ST_PARSE)
      begin
         if (prn && rx_take)
         begin
            w_in.valid = 1'b1;
            w_in.word.kind = agw_pkg::MSG_PCHAR;
            w_in.word.data = {8'h00, i_rx_data};
         end
         else if (num_fire && (cmd_reg == agw_pkg::CMD_WRITE) && (pidx_reg != 4'h0))
         begin
            w_in.valid = 1'b1;
            w_in.word.kind = agw_pkg::MSG_WRITE;
            w_in.word.addr = waddr_reg;
            w_in.word.data = fin_num;
         end
      end
      else if (st_reg == ST_EXEC)
      begin
         case (cmd_reg)
            agw_pkg::CMD_READ:
            begin
               exec_push = 1'b1;
               w_in.word.kind = agw_pkg::MSG_READ;
               w_in.word.addr = reg0_reg;
               w_in.word.data = rd_cnt;
            end
            agw_pkg::CMD_BIT:
            begin
               exec_push = 1'b1;
               w_in.word.kind = agw_pkg::MSG_READ;
               w_in.word.addr = reg0_reg;
               w_in.word.data = 16'h0001;
            end
            agw_pkg::CMD_SET, agw_pkg::CMD_CLR:
            begin
               exec_push = bit_ok;
               w_in.word.kind = (cmd_reg == agw_pkg::CMD_SET) ?
                  agw_pkg::MSG_SET : agw_pkg::MSG_CLR;
               w_in.word.addr = reg0_reg;
               w_in.word.data = 16'h0001 << bitpos;
            end
            agw_pkg::CMD_PRINT, agw_pkg::CMD_OMIT:
            begin
               exec_push = 1'b1;
               w_in.word.kind = agw_pkg::MSG_PEND;
               // Bit 0 asks the far end to append CR LF
               w_in.word.data = {15'h0000, cmd_reg == agw_pkg::CMD_PRINT};
            end
            default:
               exec_push = 1'b0;
         endcase
         w_in.valid = exec_push;
      end
   end

   assign exec_go = !exec_push || w_in.ready;
   assign rsp_take = i_rsp_valid && o_rsp_ready;
   assign o_rsp_ready = (st_reg == ST_RSP) && !fmt.busy;

   // =============================================
   // Reply formatting requests
   always_comb
   begin
      fmt.start = 1'b0;
      fmt.dec = 1'b0;
      fmt.value = i_rsp_data;
      fmt.suffix = `AGW_CH_CR;
      if ((st_reg == ST_EXEC) && (cmd_reg == agw_pkg::CMD_ADDR))
         fmt.start = 1'b1;
      else if (rsp_take)
      begin
         fmt.start = 1'b1;
         if (cmd_reg == agw_pkg::CMD_BIT)
            fmt.suffix = `AGW_CH_0 | {7'h00, i_rsp_data[bitpos]};
         else
         begin
            fmt.dec = 1'b1;
            fmt.suffix = (rcnt_reg == 16'h0001) ? `AGW_CH_CR : `AGW_CH_SP;
         end
      end
   end

   // =============================================
   // Sequencing
   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         ST_IDLE:
            if (rx_take && !is_cr)
               st_next = ST_PARSE;
         ST_PARSE:
            if (end_evt)
               st_next = ST_EXEC;
         ST_EXEC:
            if (exec_go)
            begin
               if (exec_push && ((cmd_reg == agw_pkg::CMD_READ) ||
                   (cmd_reg == agw_pkg::CMD_BIT)))
                  st_next = ST_RSP;
               else if (cmd_reg == agw_pkg::CMD_ADDR)
                  st_next = ST_REPLY;
               else
                  st_next = ST_IDLE;
            end
         ST_RSP:
            if (rsp_take && ((cmd_reg == agw_pkg::CMD_BIT) || (rcnt_reg == 16'h0001)))
               st_next = ST_REPLY;
         ST_REPLY:
            if (!fmt.busy)
               st_next = ST_IDLE;
         default:
            st_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         st_reg <= ST_IDLE;
      else
         st_reg <= st_next;
   end

   // =============================================
   // Parameter collection
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         cmd_reg <= agw_pkg::CMD_NONE;
         innum_reg <= 1'b0;
         num_reg <= 16'h0000;
         pidx_reg <= 4'h0;
         reg0_reg <= 16'h0000;
         p1_reg <= 16'h0000;
         waddr_reg <= 16'h0000;
         nchar_reg <= 8'h00;
         nroute_reg <= '0;
         nlen_reg <= 4'h0;
      end
      else if ((st_reg == ST_IDLE) && rx_take)
      begin
         cmd_reg <= dec_cmd(i_rx_data);
         innum_reg <= 1'b0;
         num_reg <= 16'h0000;
         pidx_reg <= 4'h0;
         p1_reg <= 16'h0000;
         nchar_reg <= 8'h01;
         nlen_reg <= 4'h0;
      end
      else if (st_reg == ST_PARSE)
      begin
         if (rx_take)
         begin
            nchar_reg <= nchar_reg + 8'h01;
            innum_reg <= is_dig;
            num_reg <= is_dig ? num_acc : 16'h0000;
         end
         if (num_fire)
         begin
            if (pidx_reg != `AGW_PIDX_MAX)
               pidx_reg <= pidx_reg + 4'h1;
            if (pidx_reg == 4'h0)
            begin
               reg0_reg <= fin_num;
               waddr_reg <= fin_num;
            end
            else if (cmd_reg == agw_pkg::CMD_WRITE)
               waddr_reg <= waddr_reg + 16'h0001;
            if (pidx_reg == 4'h1)
               p1_reg <= fin_num;
            if ((cmd_reg == agw_pkg::CMD_ADDR) && (pidx_reg < `AGW_ROUTE_MAX))
            begin
               nroute_reg[pidx_reg[2:0]] <= fin_num[7:0];
               nlen_reg <= pidx_reg + 4'h1;
            end
         end
      end
   end

   // =============================================
   // Inter-character timer
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         tmo_reg <= 32'h0000_0000;
      else if ((st_reg != ST_PARSE) || rx_take || !w_in.ready)
         tmo_reg <= 32'h0000_0000;
      else if (!tmo_hit)
         tmo_reg <= tmo_reg + 32'h0000_0001;
   end

   // =============================================
   // Read reply countdown
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         rcnt_reg <= 16'h0000;
      else if ((st_reg == ST_EXEC) && exec_go)
         rcnt_reg <= (cmd_reg == agw_pkg::CMD_BIT) ? 16'h0001 : rd_cnt;
      else if (rsp_take)
         rcnt_reg <= rcnt_reg - 16'h0001;
   end

   // =============================================
   // Target route; a configuration write in the same cycle wins
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         route_reg <= '0;
         rlen_reg <= 4'h0;
      end
      else if (i_cfg_we)
      begin
         route_reg <= i_cfg_drops;
         rlen_reg <= (i_cfg_len > `AGW_ROUTE_MAX) ? `AGW_ROUTE_MAX : i_cfg_len;
      end
      else if ((st_reg == ST_EXEC) && (cmd_reg == agw_pkg::CMD_ADDR))
      begin
         route_reg <= nroute_reg;
         rlen_reg <= nlen_reg;
      end
   end

   assign o_route = route_reg;
   assign o_route_len = rlen_reg;

   // =============================================
   // Buffer toward the network and reply formatter
   agw_fifo2 u_buf (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_in(w_in),
      .o_out(w_out)
   );

   assign w_out.ready = i_msg_ready;
   assign o_msg_valid = w_out.valid;
   assign o_msg_kind = w_out.word.kind;
   assign o_msg_local = w_out.word.local_tgt;
   assign o_msg_addr = w_out.word.addr;
   assign o_msg_data = w_out.word.data;

   agw_dec_fmt u_fmt (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .f(fmt),
      .o_tx_valid(o_tx_valid),
      .o_tx_data(o_tx_data),
      .i_tx_ready(i_tx_ready)
   );
endmodule

/* hw/agw_if.sv */
// Carriers between the gateway and its buffer and formatter
`timescale 1ns/10ps
interface agw_word_if;
   logic valid;
   logic ready;
   agw_pkg::agw_word_s word;
   modport src(output valid, output word, input ready);
   modport snk(input valid, input word, output ready);
endinterface

interface agw_fmt_if;
   logic start;
   logic dec;
   logic [15:0] value;
   logic [7:0] suffix;
   logic busy;
   modport ctl(output start, output dec, output value, output suffix, input busy);
   modport fmt(input start, input dec, input value, input suffix, output busy);
endinterface

/* hw/agw_pkg.sv */
// Types shared by the gateway modules
package agw_pkg;
   typedef enum logic [3:0] {CMD_NONE, CMD_READ, CMD_WRITE, CMD_SET, CMD_CLR,
      CMD_BIT, CMD_PRINT, CMD_OMIT, CMD_ADDR} agw_cmd_e;
   typedef enum logic [2:0] {MSG_READ, MSG_WRITE, MSG_SET, MSG_CLR,
      MSG_PCHAR, MSG_PEND} agw_msg_e;
   typedef struct packed {
      agw_msg_e kind;
      logic local_tgt;
      logic [15:0] addr;
      logic [15:0] data;
   } agw_word_s;
endpackage

/* sim/agw_gateway_properties.sv */
// Port-level property checker for the ASCII gateway port
`timescale 1ns/10ps
`include "agw_cfg.svh"
module agw_gateway_properties #(
   parameter int unsigned TMO_CYC = `AGW_TMO_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic o_msg_valid,
   input wire logic i_msg_ready,
   input wire logic [2:0] o_msg_kind,
   input wire logic o_msg_local,
   input wire logic [15:0] o_msg_addr,
   input wire logic [15:0] o_msg_data,
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   input wire logic i_cfg_we,
   input wire logic [3:0] i_cfg_len,
   input wire logic [3:0] o_route_len
);
   // ==========================================
   // Properties
   default clocking cb @(posedge i_clk);
   endclocking
   property p_reset;
      !i_rst_n |=> !o_msg_valid && !o_tx_valid && o_route_len == 4'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
   property p_hold_msg;
      disable iff (!i_rst_n) o_msg_valid && !i_msg_ready |=> o_msg_valid
         && $stable(o_msg_kind) && $stable(o_msg_addr) && $stable(o_msg_data);
   endproperty
   a_hold_msg: assert property (p_hold_msg) else $error("message changed while stalled");
   property p_hold_tx;
      disable iff (!i_rst_n) o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
   endproperty
   a_hold_tx: assert property (p_hold_tx) else $error("reply char changed while stalled");
   property p_set;
      disable iff (!i_rst_n) o_msg_valid && o_msg_kind == 3'h2 |-> $onehot(o_msg_data);
   endproperty
   a_set: assert property (p_set) else $error("set mask not one bit");
   property p_clr;
      disable iff (!i_rst_n) o_msg_valid && o_msg_kind == 3'h3 |-> $countones(o_msg_data) == 1;
   endproperty
   a_clr: assert property (p_clr) else $error("clear mask not one bit");
   property p_local;
      disable iff (!i_rst_n) o_msg_valid && o_msg_kind < 3'h4
         |-> o_msg_local == (o_route_len == 4'h0);
   endproperty
   a_local: assert property (p_local) else $error("local flag disagrees with route");
   property p_cfg;
      disable iff (!i_rst_n) i_cfg_we
         |=> o_route_len == ($past(i_cfg_len) > 4'h8 ? 4'h8 : $past(i_cfg_len));
   endproperty
   a_cfg: assert property (p_cfg) else $error("route length not taken from config");
   property p_txch;
      disable iff (!i_rst_n) o_tx_valid
         |-> o_tx_data inside {[`AGW_CH_0:`AGW_CH_9], `AGW_CH_SP, `AGW_CH_CR};
   endproperty
   a_txch: assert property (p_txch) else $error("reply char not digit space or CR");
endmodule

bind agw_gateway agw_gateway_properties #(.TMO_CYC(TMO_CYC)) u_props (.i_clk, .i_rst_n,
   .o_msg_valid, .i_msg_ready, .o_msg_kind, .o_msg_local, .o_msg_addr, .o_msg_data,
   .o_tx_valid, .o_tx_data, .i_tx_ready, .i_cfg_we, .i_cfg_len, .o_route_len);

/* sim/agw_net_model.sv */
// Behavioural network side: register store answering read, write and bit messages
`timescale 1ns/10ps
module agw_net_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [2:0] i_kind,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_data,
   output logic o_ready,
   output logic o_rsp_valid,
   output logic [15:0] o_rsp_data,
   input wire logic i_rsp_ready
);
   logic [15:0] mem [0:63];
   logic [15:0] ra;
   integer pend = 0;
   integer seed = 89;
   initial
   begin
      o_ready = 0;
      o_rsp_valid = 0;
      o_rsp_data = 0;
      for (int k = 0; k < 64; k++)
         mem[k] = 16'(k * 11);
   end
   // ==========================================
   // Handshakes sampled at the edge, outputs moved just after it
   always @(posedge i_clk)
   begin
      if (i_valid && o_ready)
      begin
         case (i_kind)
            3'h0:
            begin
               pend = i_data;
               ra = i_addr;
            end
            3'h1: mem[i_addr[5:0]] = i_data;
            3'h2: mem[i_addr[5:0]] = mem[i_addr[5:0]] | i_data;
            3'h3: mem[i_addr[5:0]] = mem[i_addr[5:0]] & ~i_data;
            default: ;
         endcase
      end
      if (o_rsp_valid && i_rsp_ready)
      begin
         pend = pend - 1;
         ra = ra + 16'h0001;
      end
      if (!i_rst_n)
         pend = 0;
      #2;
      // Stalls now and then so the two-entry buffer sees back-pressure
      o_ready = ($random(seed) % 4) != 0;
      o_rsp_valid = pend > 0;
      // Idle data toggles so no stale value can pass for an answer
      o_rsp_data = o_rsp_valid ? mem[ra[5:0]] : ~o_rsp_data;
   end
endmodule

/* sim/tb_agw_gateway.sv */
// Self-checking bench for the ASCII gateway port
`timescale 1ns/10ps
module tb_agw_gateway;
   logic i_clk = 0, i_rst_n = 0, i_rx_valid = 0, i_tx_ready = 0, i_cfg_we = 0;
   logic [7:0] i_rx_data = 0;
   logic [3:0] i_cfg_len = 0;
   logic [63:0] i_cfg_drops = 0;
   logic o_rx_ready, o_msg_valid, i_msg_ready, o_msg_local, i_rsp_valid, o_rsp_ready;
   logic o_tx_valid;
   logic [2:0] o_msg_kind;
   logic [15:0] o_msg_addr, o_msg_data, i_rsp_data, v;
   logic [7:0] o_tx_data;
   logic [3:0] o_route_len;
   logic [63:0] o_route;
   logic [35:0] mq[$];
   string rx_s = "";
   integer seed = 89, checks = 0, n_mismatch = 0, cyc = 0, r;
   // Short idle limit keeps the time-ended commands fast
   agw_gateway #(.TMO_CYC(50)) i_dut (.i_clk, .i_rst_n, .i_rx_valid, .i_rx_data, .o_rx_ready,
      .o_msg_valid, .i_msg_ready, .o_msg_kind, .o_msg_local, .o_msg_addr, .o_msg_data,
      .i_rsp_valid, .i_rsp_data, .o_rsp_ready, .o_tx_valid, .o_tx_data, .i_tx_ready,
      .i_cfg_we, .i_cfg_len, .i_cfg_drops, .o_route_len, .o_route);
   agw_net_model i_net (.i_clk, .i_rst_n, .i_valid(o_msg_valid), .i_kind(o_msg_kind),
      .i_addr(o_msg_addr), .i_data(o_msg_data), .o_ready(i_msg_ready),
      .o_rsp_valid(i_rsp_valid), .o_rsp_data(i_rsp_data), .i_rsp_ready(o_rsp_ready));
   initial
      forever #12.5 i_clk = ~i_clk;
   // ==========================================
   // Monitors, host stall and hang guard
   always @(posedge i_clk)
   begin
      if (o_tx_valid && i_tx_ready)
         rx_s = $sformatf("%s%c", rx_s, o_tx_data);
      if (o_msg_valid && i_msg_ready)
         mq.push_back({o_msg_kind, o_msg_local, o_msg_addr, o_msg_data});
      #2;
      i_tx_ready = ($random(seed) % 3) != 0;
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_val(input string n, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_msg(input logic [2:0] k, input logic l, input logic [15:0] a,
      input logic [15:0] d);
      logic [35:0] g;
      for (int i = 0; i < 600 && mq.size() == 0; i++)
         @(posedge i_clk);
      #2;
      g = (mq.size() > 0) ? mq.pop_front() : 36'bx;
      // Print words carry no register number
      if (k >= 3'h4)
         {l, a} = g[32:16];
      chk_val("message", {k, l, a, d}, g);
   endtask
   task automatic chk_txt(input string e);
      for (int i = 0; i < 2000 && rx_s.len() < e.len(); i++)
         @(posedge i_clk);
      #2;
      checks++;
      if (rx_s != e)
      begin
         n_mismatch++;
         $display("MISMATCH reply expected %s seen %s", e, rx_s);
      end
      rx_s = "";
   endtask
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++)
      begin
         i_rx_valid = 1'b1;
         i_rx_data = s[i];
         do @(posedge i_clk); while (o_rx_ready !== 1'b1);
         #2;
      end
      i_rx_valid = 1'b0;
      @(posedge i_clk);
      #2;
   endtask
   task automatic done(input string n);
      $display("test %s finished", n);
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      repeat (3) @(posedge i_clk);
      #2;
      i_rst_n = 1;
      chk_val("route_len", 0, o_route_len);
      send("A8,10\r");
      chk_txt("\r");
      chk_val("route", 64'h0a08, o_route);
      send("ADDRESS 1 2 3 4 5 6 7 8 9\r");
      chk_txt("\r");
      chk_val("route_len", 8, o_route_len);
      send("A\r");
      chk_txt("\r");
      done("address");
      send("w12.55,67\r");
      chk_msg(1, 1, 12, 55);
      chk_msg(1, 1, 13, 67);
      send("read12 for 2\r");
      chk_msg(0, 1, 12, 2);
      chk_txt("55 67\r");
      send("Ralph 7\r");
      chk_msg(0, 1, 7, 1);
      chk_txt("77\r");
      send("s12.16\r");
      chk_msg(2, 1, 12, 16'h8000);
      send("S12.0\r");
      send("c12.1\r");
      chk_msg(3, 1, 12, 16'h0001);
      send("Bit 12 16\r");
      chk_msg(0, 1, 12, 1);
      chk_txt("1");
      send("b12 1\r");
      chk_msg(0, 1, 12, 1);
      chk_txt("0");
      done("read write bit");
      send("P++\r");
      repeat (2) chk_msg(4, 0, 0, "+");
      chk_msg(4, 0, 0, "\r");
      chk_msg(5, 0, 0, 16'h0001);
      send("O+++");
      repeat (3) chk_msg(4, 0, 0, 16'h002b);
      chk_msg(5, 0, 0, 16'h0000);
      send("A5\r");
      chk_txt("\r");
      send("W3 9\r");
      chk_msg(1, 0, 3, 9);
      i_cfg_len = 4'hc;
      i_cfg_drops = 64'h0807_0605_0403_0201;
      i_cfg_we = 1;
      @(posedge i_clk);
      #2;
      i_cfg_we = 0;
      chk_val("route", 64'h0807_0605_0403_0201, o_route);
      send("A\r");
      chk_txt("\r");
      done("print and route");
      repeat (6)
      begin
         r = {$random(seed)} % 64;
         v = $random(seed);
         send($sformatf("W%0d %0d\r", r, v));
         chk_msg(1, 1, r[15:0], v);
         send($sformatf("r%0d\r", r));
         chk_msg(0, 1, r[15:0], 1);
         chk_txt($sformatf("%0d\r", v));
      end
      done("random");
      tally_and_finish;
   end
endmodule
